//--- bench/motor_model.sv
// Motor and load model facing the sequencer's drive outputs
module motor_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire brake_seq_pkg::drive_ctl_t drive_ctl,
  input wire logic [13:0] spin_rpm,
  input wire logic [13:0] coast_step,
  output logic [13:0] motor_speed,
  output logic motor_stopped
);
  timeunit 1ns;
  timeprecision 1ps;
  logic braking;
  assign braking = drive_ctl.winding_short | drive_ctl.zero_speed_cmd | drive_ctl.slow_down;
  // Active stopping sheds speed each cycle, otherwise the load sets it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      motor_speed <= 14'h0000;
    end else if (braking) begin
      motor_speed <= (motor_speed > coast_step) ? motor_speed - coast_step : 14'h0000;
    end else begin
      motor_speed <= spin_rpm;
    end
  end
  assign motor_stopped = (motor_speed == 14'h0000);
endmodule

//--- bench/tb.sv
// Self-checking bench for the brake output sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, servo_on_command, servo_off_command, alarm, alarm_zero_speed_ok;
  logic overtravel, motor_stopped, brake_release_out, busy;
  logic [13:0] motor_speed, spin_rpm, coast_step;
  logic [2:0] exp_m;
  brake_seq_pkg::brake_cfg_t cfg;
  brake_seq_pkg::drive_ctl_t drive_ctl;
  int mismatches, tests_run, n;

  brake_output_sequencer #(.TICK_CYCLES(10)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .servo_on_command(servo_on_command), .servo_off_command(servo_off_command),
    .alarm(alarm), .alarm_zero_speed_ok(alarm_zero_speed_ok), .overtravel(overtravel),
    .motor_stopped(motor_stopped), .motor_speed(motor_speed), .cfg(cfg),
    .brake_release_out(brake_release_out), .drive_ctl(drive_ctl), .busy(busy));
  motor_model motor (.core_clk(core_clk), .rst_n(rst_n), .drive_ctl(drive_ctl),
    .spin_rpm(spin_rpm), .coast_step(coast_step), .motor_speed(motor_speed),
    .motor_stopped(motor_stopped));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic conclude;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for brake_release_out (which 0) or busy (which 1) to reach v
  task automatic wait_for(input int which, input logic v, input int lim);
    n = 0;
    while (((which == 1) ? busy : brake_release_out) !== v && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, n, lim);
      conclude();
    end
  endtask

  task automatic restart_on(input logic [13:0] rpm);
    alarm = 1'b0;
    servo_off_command = 1'b0;
    spin_rpm = rpm;
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    servo_on_command = 1'b1;
    step(5);
    servo_on_command = 1'b0;
    chk(brake_release_out, 1);
    chk(drive_ctl.energized, 1);
  endtask

  initial begin
    rst_n = 1'b0;
    servo_on_command = 1'b0;
    servo_off_command = 1'b0;
    alarm = 1'b0;
    alarm_zero_speed_ok = 1'b1;
    overtravel = 1'b0;
    spin_rpm = 14'h0000;
    coast_step = 14'h0000;
    mismatches = 0;
    tests_run = 0;
    cfg = '{delay_ms: 14'h0003, speed_thresh: 14'h0064, wait_10ms: 7'h05,
      motor_max_speed: 14'h07D0, alarm_stop: brake_seq_pkg::STOP_FREE_RUN,
      post_stop: brake_seq_pkg::POST_ZERO_HOLD};
    step(20);
    rst_n = 1'b1;
    step(1);
    chk({brake_release_out, busy, drive_ctl}, 16'h0000);
    // Stationary servo off with a 3 ms delay
    restart_on(14'h0000);
    servo_off_command = 1'b1;
    step(4);
    chk(brake_release_out, 0);
    chk(drive_ctl.energized, 1);
    wait_for(1, 1'b0, 60);
    chk(n >= 20 && n <= 35, 1);
    chk(drive_ctl, 5'h11);
    cfg.post_stop = brake_seq_pkg::POST_FREE_RUN;
    restart_on(14'h0000);
    servo_off_command = 1'b1;
    step(4);
    wait_for(1, 1'b0, 60);
    chk(drive_ctl, 5'h00);
    // Alarm while stationary ignores the delay
    cfg.post_stop = brake_seq_pkg::POST_WINDING_SHORT;
    restart_on(14'h0000);
    alarm = 1'b1;
    step(4);
    chk({brake_release_out, drive_ctl.energized}, 0);
    chk(drive_ctl, 5'h08);
    // Alarm during the servo-off delay cuts power at once
    restart_on(14'h0000);
    servo_off_command = 1'b1;
    step(4);
    alarm = 1'b1;
    step(3);
    chk(drive_ctl.energized, 0);
    // Every stop method with an alarm while rotating
    for (int m = 0; m < 4; m++) begin
      cfg.alarm_stop = brake_seq_pkg::stop_method_t'(m);
      coast_step = 14'h0000;
      restart_on(14'h03E8);
      alarm = 1'b1;
      step(5);
      exp_m = (m == 0) ? 3'b100 : (m == 2) ? 3'b010 : (m == 3) ? 3'b001 : 3'b000;
      chk(drive_ctl[3:1], exp_m);
      chk(brake_release_out, 1);
      spin_rpm = 14'h0000;
      coast_step = 14'h0064;
      wait_for(1, 1'b0, 90);
      chk(brake_release_out, 0);
      if (m == 2) chk(n >= 20, 1);
    end
    // Zero-speed stop only where the alarm permits it
    cfg.alarm_stop = brake_seq_pkg::STOP_ZERO_SPEED;
    alarm_zero_speed_ok = 1'b0;
    restart_on(14'h03E8);
    alarm = 1'b1;
    step(5);
    chk(drive_ctl[3:1], 3'b000);
    alarm_zero_speed_ok = 1'b1;
    // Wait timer expiry, programmed 5 clamps to 10 units
    cfg.alarm_stop = brake_seq_pkg::STOP_FREE_RUN;
    coast_step = 14'h0000;
    restart_on(14'h03E8);
    alarm = 1'b1;
    wait_for(0, 1'b0, 1300);
    chk(n >= 950 && n <= 1050, 1);
    // Threshold above maximum speed is clamped
    cfg.speed_thresh = 14'h0BB8;
    restart_on(14'h09C4);
    alarm = 1'b1;
    step(20);
    chk(brake_release_out, 1);
    // Overtravel keeps the brake released
    restart_on(14'h0000);
    overtravel = 1'b1;
    servo_off_command = 1'b1;
    step(6);
    chk(brake_release_out, 1);
    overtravel = 1'b0;
    step(5);
    chk(brake_release_out, 0);
    conclude();
  end
endmodule

//--- design/brake_output_sequencer.sv
// Brake release output and de-energize sequencer
// Overview of operation
// - Servo-off while stationary drops brake release so the brake engages.
// - Stationary servo-off keeps motor energized for programmed 0..10000 ms delay.
// - Alarm removes motor power at once, ignoring the delay, unless a zero-speed alarm stop is running.
// - Alarm while rotating stops the motor, then drops brake release later.
// - After de-energize, engage brake once speed falls below threshold (default 100).
// - Also engage brake when wait time (10..100 x 10 ms, default 50) expires.
// - Effective speed threshold is clamped to motor maximum speed.
// - Zero-speed alarm stop applies the brake delay after the motor rests.
// - Winding-short stop shorts the winding to stop urgently.
// - Free-running stop withdraws drive; motor coasts by friction.
// - Zero-speed stop forces the internal speed command to zero.
// - Slow-down stop decelerates with emergency-stop torque.
// - Free-running post-stop state exerts no control over the motor.
// - Zero-position post-stop state holds position with zero command unless alarm is active.
// - Default alarm stop method is zero-speed stop.
// - Brake release high releases brake; low on servo off or alarm except in S_COAST, S_ALM_STOP or overtravel.
// - Overtravel keeps brake release asserted.
module brake_output_sequencer #(
  parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic servo_on_command,
  input wire logic servo_off_command,
  input wire logic alarm,
  input wire logic alarm_zero_speed_ok,
  input wire logic overtravel,
  input wire logic motor_stopped,
  input wire logic [13:0] motor_speed,
  input wire brake_seq_pkg::brake_cfg_t cfg,
  output logic brake_release_out,
  output brake_seq_pkg::drive_ctl_t drive_ctl,
  output logic busy
);
  initial begin
    if (TICK_CYCLES < 2) $error("brake_output_sequencer: TICK_CYCLES too small");
  end

  typedef enum logic [2:0] {
    S_OFF,
    S_ON,
    S_DELAY,
    S_ALM_STOP,
    S_ALM_DELAY,
    S_COAST,
    S_DONE
  } seq_state_t;

  logic tick;
  ms_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Command, alarm, overtravel and stopped pins pass two flops
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {servo_on_command, servo_off_command, alarm, overtravel, motor_stopped};
      sync2_q <= sync1_q;
    end
  end
  logic on_cmd, off_cmd, alm, ot, stopped;
  assign {on_cmd, off_cmd, alm, ot, stopped} = sync2_q;

  function automatic logic [13:0] clamp_speed(input logic [13:0] v, input logic [13:0] mx);
    clamp_speed = (v > mx) ? mx : v;
  endfunction

  function automatic logic [6:0] clamp_wait(input logic [6:0] w);
    if (w < brake_seq_pkg::WAIT_MIN) clamp_wait = brake_seq_pkg::WAIT_MIN;
    else if (w > brake_seq_pkg::WAIT_MAX) clamp_wait = brake_seq_pkg::WAIT_MAX;
    else clamp_wait = w;
  endfunction

  logic [13:0] eff_thresh;
  logic [16:0] wait_ms;
  assign eff_thresh = clamp_speed(cfg.speed_thresh, cfg.motor_max_speed);
  assign wait_ms = 17'(clamp_wait(cfg.wait_10ms) * brake_seq_pkg::WAIT_UNIT_MS);

  seq_state_t st_q, st_d;
  logic [16:0] tmr_q, tmr_d;
  logic rel_q, rel_d;
  brake_seq_pkg::drive_ctl_t ctl_q, ctl_d;
  logic busy_q, busy_d;
  logic alm_q, alm_rise;
  assign alm_rise = alm & ~alm_q;

  always_comb begin
    st_d = st_q;
    tmr_d = tick ? tmr_q + 17'h00001 : tmr_q;
    unique case (st_q)
      S_OFF: begin
        tmr_d = '0;
        if (on_cmd && !alm) st_d = S_ON;
      end
      S_ON: begin
        tmr_d = '0;
        if (alm) begin
          if (stopped) st_d = S_DONE;
          else if (alarm_zero_speed_ok && cfg.alarm_stop == brake_seq_pkg::STOP_ZERO_SPEED)
            st_d = S_ALM_STOP;
          else st_d = S_COAST;
        end else if (off_cmd) begin
          st_d = stopped ? S_DELAY : S_COAST;
        end
      end
      S_DELAY: begin
        if (alm) st_d = S_DONE;
        else if (tmr_q >= 17'(cfg.delay_ms)) st_d = S_DONE;
      end
      S_ALM_STOP: begin
        tmr_d = '0;
        if (stopped) st_d = S_ALM_DELAY;
      end
      S_ALM_DELAY: begin
        if (tmr_q >= 17'(cfg.delay_ms)) st_d = S_DONE;
      end
      S_COAST: begin
        if (motor_speed < eff_thresh || tmr_q >= wait_ms) st_d = S_DONE;
      end
      S_DONE: begin
        tmr_d = '0;
        if (!alm && !off_cmd && on_cmd) st_d = S_ON;
      end
    endcase
    if (alm_rise && st_q == S_COAST) tmr_d = '0;
  end

  always_comb begin
    rel_d = 1'b0;
    ctl_d = '0;
    busy_d = 1'b1;
    unique case (st_d)
      S_ON: begin
        rel_d = 1'b1;
        ctl_d.energized = 1'b1;
        busy_d = 1'b0;
      end
      S_DELAY, S_ALM_DELAY: begin
        ctl_d.energized = 1'b1;
        ctl_d.pos_hold = 1'b1;
      end
      S_ALM_STOP: begin
        // Brake is only a holding brake: keep it released until the motor rests
        rel_d = 1'b1;
        ctl_d.energized = 1'b1;
        ctl_d.zero_speed_cmd = 1'b1;
      end
      S_COAST: begin
        // Released until speed threshold or wait expiry ends the coast
        rel_d = 1'b1;
        unique case (cfg.alarm_stop)
          brake_seq_pkg::STOP_WINDING_SHORT: ctl_d.winding_short = 1'b1;
          brake_seq_pkg::STOP_SLOW_DOWN: ctl_d.slow_down = 1'b1;
          default: ;
        endcase
      end
      S_DONE: begin
        busy_d = 1'b0;
        unique case (cfg.post_stop)
          brake_seq_pkg::POST_WINDING_SHORT: ctl_d.winding_short = 1'b1;
          brake_seq_pkg::POST_ZERO_HOLD: begin
            ctl_d.energized = !alm;
            ctl_d.pos_hold = !alm;
          end
          default: ;
        endcase
      end
      default: busy_d = 1'b0;
    endcase
    if (ot) rel_d = 1'b1;
    else if ((alm || off_cmd) && st_d != S_COAST && st_d != S_ALM_STOP)
      rel_d = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= S_OFF;
      tmr_q <= '0;
      rel_q <= 1'b0;
      ctl_q <= '0;
      busy_q <= 1'b0;
      alm_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      rel_q <= rel_d;
      ctl_q <= ctl_d;
      busy_q <= busy_d;
      alm_q <= alm;
    end
  end

  assign brake_release_out = rel_q;
  assign drive_ctl = ctl_q;
  assign busy = busy_q;

  sequence alm_seen;
    alm && !ot && st_d != S_COAST && st_d != S_ALM_STOP;
  endsequence

  a_alarm_drops_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    alm_seen |=> !brake_release_out) else $error("release held during alarm");
  a_overtravel_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    ot |=> brake_release_out) else $error("release dropped in overtravel");
  a_alarm_power_cut: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_DELAY && alm) |=> !drive_ctl.energized) else $error("power kept on alarm");
  a_delay_energized: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_DELAY && tmr_q < 17'(cfg.delay_ms) && !alm) |=> drive_ctl.energized)
    else $error("motor not energized during delay");
  a_off_brake_engage: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_ON && off_cmd && stopped && !alm && !ot) |=> !brake_release_out)
    else $error("brake not engaged on servo off");
  a_speed_done: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_COAST && motor_speed < eff_thresh) |=> st_q == S_DONE)
    else $error("brake not engaged below speed");
  a_wait_done: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_COAST && tmr_q >= wait_ms) |=> st_q == S_DONE)
    else $error("wait expiry ignored");
  a_clamp_thresh: assert property (@(posedge core_clk) disable iff (!rst_n)
    eff_thresh <= cfg.motor_max_speed) else $error("threshold above max speed");
  a_zero_speed_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_ALM_STOP) |-> drive_ctl.zero_speed_cmd && drive_ctl.energized)
    else $error("zero speed command missing");
  a_tick_timer: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_DELAY && !tick && st_d == S_DELAY) |=> $stable(tmr_q))
    else $error("timer moved without tick");
endmodule

//--- design/brake_seq_pkg.sv
// Shared types and constants for the brake output sequencer
package brake_seq_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DELAY_MAX_MS = 10000;
  localparam logic [13:0] DELAY_DEFAULT = 14'h0000;
  localparam int SPEED_MAX_RPM = 10000;
  localparam logic [13:0] SPEED_DEFAULT = 14'h0064;
  localparam int WAIT_UNIT_MS = 10;
  localparam logic [6:0] WAIT_MIN = 7'h0A;
  localparam logic [6:0] WAIT_MAX = 7'h64;
  localparam logic [6:0] WAIT_DEFAULT = 7'h32;

  typedef enum logic [1:0] {
    STOP_WINDING_SHORT,
    STOP_FREE_RUN,
    STOP_ZERO_SPEED,
    STOP_SLOW_DOWN
  } stop_method_t;

  typedef enum logic [1:0] {
    POST_WINDING_SHORT,
    POST_FREE_RUN,
    POST_ZERO_HOLD
  } post_state_t;

  typedef struct packed {
    logic [13:0] delay_ms;
    logic [13:0] speed_thresh;
    logic [6:0] wait_10ms;
    logic [13:0] motor_max_speed;
    stop_method_t alarm_stop;
    post_state_t post_stop;
  } brake_cfg_t;

  typedef struct packed {
    logic energized;
    logic winding_short;
    logic zero_speed_cmd;
    logic slow_down;
    logic pos_hold;
  } drive_ctl_t;
endpackage

//--- design/ms_tick_gen.sv
// Millisecond tick divider
module ms_tick_gen #(
  parameter int CYCLES = brake_seq_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic tick
);
  initial begin
    if (CYCLES < 2) $error("ms_tick_gen: CYCLES must be at least 2");
  end
  logic [$clog2(CYCLES)-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  localparam logic [$clog2(CYCLES)-1:0] LAST = ($clog2(CYCLES))'(CYCLES - 1);

  always_comb begin
    cnt_d = cnt_q + 1'b1;
    tick_d = 1'b0;
    if (cnt_q == LAST) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule
